/* File: core/edcm_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "edcm_map.vh"

module edcm_det (
    input wire mclk,
    input wire rst,
    input wire enable,
    input wire tick,
    input wire sample_strobe,
    input wire [6:0] envelope,
    input wire [6:0] low_thr,
    input wire [6:0] high_thr,
    output reg [7:0] result_reg,
    output reg irq_reg,
    output reg flag_reg
);
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_TIME = 2'b10;

    reg [1:0] state_reg;
    reg [6:0] count_reg;
    reg side_reg;
    reg maxed_reg;
    reg [6:0] peak_reg;

    wire above = envelope > high_thr;
    wire below = envelope < low_thr;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_WAIT;
            count_reg <= `EDCM_CNT_ZERO;
            side_reg <= 1'b0;
            maxed_reg <= 1'b0;
            peak_reg <= `EDCM_THR_RST;
            result_reg <= `EDCM_RES_RST;
            irq_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else if (!enable) begin
            // Held in reset
            state_reg <= ST_WAIT;
            count_reg <= `EDCM_CNT_ZERO;
            side_reg <= 1'b0;
            maxed_reg <= 1'b0;
            peak_reg <= `EDCM_THR_RST;
            result_reg <= `EDCM_RES_RST;
            irq_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            if (sample_strobe) begin
                peak_reg <= envelope;
            end
            if (tick && state_reg == ST_TIME && count_reg != `EDCM_CNT_MAX) begin
                count_reg <= count_reg + 7'h01;
            end
            case (state_reg)
                ST_WAIT: begin
                    if (sample_strobe && above) begin
                        side_reg <= 1'b1;
                        flag_reg <= 1'b1;
                        count_reg <= `EDCM_CNT_ZERO;
                        state_reg <= ST_TIME;
                    end else if (sample_strobe && below) begin
                        side_reg <= 1'b0;
                        flag_reg <= 1'b0;
                        count_reg <= `EDCM_CNT_ZERO;
                        state_reg <= ST_TIME;
                    end
                end
                ST_TIME: begin
                    if (sample_strobe && ((above && !side_reg) || (below && side_reg))) begin
                        result_reg[`EDCM_SIDE_BIT] <= ~side_reg;
                        result_reg[`EDCM_CNT_MSB:0] <= count_reg;
                        side_reg <= ~side_reg;
                        flag_reg <= ~side_reg;
                        count_reg <= `EDCM_CNT_ZERO;
                        maxed_reg <= 1'b0;
                        irq_reg <= 1'b1;
                    end else if (count_reg == `EDCM_CNT_MAX && !maxed_reg) begin
                        result_reg[`EDCM_CNT_MSB:0] <= `EDCM_CNT_MAX;
                        maxed_reg <= 1'b1;
                        irq_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_WAIT;
                end
            endcase
        end
    end
endmodule // edcm_det

module edcm_top #(
    parameter TICK_CYCLES = `EDCM_TICK_US * `EDCM_CLK_MHZ
) (
    input wire mclk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire pcm_valid,
    input wire [7:0] pcm_channel,
    input wire [7:0] pcm_data,
    output wire irq_a,
    output wire irq_b
);
    reg [1:0] ctrl_reg;
    reg [1:0] ctrl_next;
    reg [6:0] a_low_reg;
    reg [6:0] a_low_next;
    reg [6:0] a_high_reg;
    reg [6:0] a_high_next;
    reg [6:0] b_low_reg;
    reg [6:0] b_low_next;
    reg [6:0] b_high_reg;
    reg [6:0] b_high_next;
    reg [7:0] a_chan_reg;
    reg [7:0] a_chan_next;
    reg [7:0] b_chan_reg;
    reg [7:0] b_chan_next;
    reg [9:0] idx_reg;
    reg wr_pend_reg;
    reg [31:0] rd_word;
    reg [19:0] div_reg;
    reg tick_reg;
    reg [6:0] env_a_reg;
    reg [6:0] env_b_reg;
    reg strobe_a_reg;
    reg strobe_b_reg;
    wire [7:0] res_a;
    wire [7:0] res_b;
    wire flag_a;
    wire flag_b;

    // Sample of a watched channel is present
    function chan_hit;
        input valid;
        input [7:0] chan;
        input [7:0] watched;
        begin
            chan_hit = valid && (chan == watched);
        end
    endfunction

    // Threshold code padded to a bus word
    function [31:0] thr_word;
        input [6:0] code;
        begin
            thr_word = {25'h0000000, code};
        end
    endfunction

    // Byte register padded to a bus word
    function [31:0] byte_word;
        input [7:0] value;
        begin
            byte_word = {24'h000000, value};
        end
    endfunction

    wire hit_a = chan_hit(pcm_valid, pcm_channel, a_chan_reg);
    wire hit_b = chan_hit(pcm_valid, pcm_channel, b_chan_reg);

    wire addr_phase = hsel && hready && htrans[1] && hsize == `EDCM_HSIZE_WORD;

    assign hreadyout = 1'b1;
    assign hresp = `EDCM_HRESP_OKAY;

    // Bus address phase capture
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            idx_reg <= 10'h000;
            wr_pend_reg <= 1'b0;
            hrdata <= 32'h00000000;
        end else if (hready) begin
            idx_reg <= haddr[11:2];
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase && !hwrite) begin
                hrdata <= rd_word;
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // Next register values while a write data phase stands
    always @* begin
        ctrl_next = ctrl_reg;
        a_low_next = a_low_reg;
        a_high_next = a_high_reg;
        b_low_next = b_low_reg;
        b_high_next = b_high_reg;
        a_chan_next = a_chan_reg;
        b_chan_next = b_chan_reg;
        if (wr_pend_reg) begin
            case (idx_reg)
                `EDCM_CTRL_IDX: ctrl_next = hwdata[`EDCM_EN_B_BIT:`EDCM_EN_A_BIT];
                `EDCM_A_LOW_IDX: a_low_next = hwdata[`EDCM_THR_MSB:0];
                `EDCM_A_HIGH_IDX: a_high_next = hwdata[`EDCM_THR_MSB:0];
                `EDCM_B_LOW_IDX: b_low_next = hwdata[`EDCM_THR_MSB:0];
                `EDCM_B_HIGH_IDX: b_high_next = hwdata[`EDCM_THR_MSB:0];
                `EDCM_A_CHAN_IDX: a_chan_next = hwdata[7:0];
                `EDCM_B_CHAN_IDX: b_chan_next = hwdata[7:0];
                `EDCM_A_RES_IDX, `EDCM_B_RES_IDX: ctrl_next = ctrl_reg;
                default: ctrl_next = ctrl_reg;
            endcase
        end
    end

    // Register writes land at the end of the data phase
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `EDCM_CTRL_RST;
            a_low_reg <= `EDCM_THR_RST;
            a_high_reg <= `EDCM_THR_RST;
            b_low_reg <= `EDCM_THR_RST;
            b_high_reg <= `EDCM_THR_RST;
            a_chan_reg <= `EDCM_CHAN_RST;
            b_chan_reg <= `EDCM_CHAN_RST;
        end else begin
            ctrl_reg <= ctrl_next;
            a_low_reg <= a_low_next;
            a_high_reg <= a_high_next;
            b_low_reg <= b_low_next;
            b_high_reg <= b_high_next;
            a_chan_reg <= a_chan_next;
            b_chan_reg <= b_chan_next;
        end
    end

    // Read word from next values, so a write is seen by the read after it
    always @* begin
        rd_word = 32'h00000000;
        case (haddr[11:2])
            `EDCM_CTRL_IDX: rd_word = {28'h0000000, flag_b, flag_a, ctrl_next};
            `EDCM_A_LOW_IDX: rd_word = thr_word(a_low_next);
            `EDCM_A_HIGH_IDX: rd_word = thr_word(a_high_next);
            `EDCM_A_RES_IDX: rd_word = byte_word(res_a);
            `EDCM_B_LOW_IDX: rd_word = thr_word(b_low_next);
            `EDCM_B_HIGH_IDX: rd_word = thr_word(b_high_next);
            `EDCM_B_RES_IDX: rd_word = byte_word(res_b);
            `EDCM_A_CHAN_IDX: rd_word = byte_word(a_chan_next);
            `EDCM_B_CHAN_IDX: rd_word = byte_word(b_chan_next);
            default: rd_word = 32'h00000000;
        endcase
    end

    // 4 ms tick divider
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end else if (div_reg == TICK_CYCLES[19:0] - 20'h00001) begin
            div_reg <= 20'h00000;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 20'h00001;
            tick_reg <= 1'b0;
        end
    end

    // Channel selection and magnitude capture
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            env_a_reg <= `EDCM_THR_RST;
            env_b_reg <= `EDCM_THR_RST;
            strobe_a_reg <= 1'b0;
            strobe_b_reg <= 1'b0;
        end else begin
            strobe_a_reg <= hit_a;
            strobe_b_reg <= hit_b;
            if (hit_a) begin
                env_a_reg <= pcm_data[`EDCM_THR_MSB:0];
            end
            if (hit_b) begin
                env_b_reg <= pcm_data[`EDCM_THR_MSB:0];
            end
        end
    end

    edcm_det det_a (
        .mclk(mclk),
        .rst(rst),
        .enable(ctrl_reg[`EDCM_EN_A_BIT]),
        .tick(tick_reg),
        .sample_strobe(strobe_a_reg),
        .envelope(env_a_reg),
        .low_thr(a_low_reg),
        .high_thr(a_high_reg),
        .result_reg(res_a),
        .irq_reg(irq_a),
        .flag_reg(flag_a)
    );

    // Independent second detector
    edcm_det det_b (
        .mclk(mclk),
        .rst(rst),
        .enable(ctrl_reg[`EDCM_EN_B_BIT]),
        .tick(tick_reg),
        .sample_strobe(strobe_b_reg),
        .envelope(env_b_reg),
        .low_thr(b_low_reg),
        .high_thr(b_high_reg),
        .result_reg(res_b),
        .irq_reg(irq_b),
        .flag_reg(flag_b)
    );
endmodule // edcm_top

`default_nettype wire

/* File: common/edcm_map.vh */
// How it works
// - Threshold is a 7-bit magnitude in bits 6..0, bit 7 unused.
// - Threshold low four bits are step, upper three bits are chord.
// - Result bit 7 shows last side crossed: 1 above high, 0 below low.
// - Result bits 6..0 hold duration in 4 ms units, 0 to 508 ms.
// - Timer starts when the envelope crosses a threshold.
// - Opposite crossing updates the side flag and raises an interrupt.
// - Opposite crossing copies the running timer into the count field.
// - Steady signal raises an interrupt when the timer reaches all ones.
// - Maximum-count interrupt leaves the side flag unchanged.
// - Result registers are read-only at 013h and 016h, zero after reset.
// - Thresholds at 012h, 014h, 015h are read/write, reset to zero.
// - Detector B has its own timer, flag and result, same behaviour.
// - Channel for A comes from location 71h, for B from 72h.
// - Clearing an enable bit holds that detector in reset.
// - Detector A low threshold is read/write at 011h, reset zero.
`ifndef EDCM_MAP_VH
`define EDCM_MAP_VH

// Register indices; byte address is four times the index
`define EDCM_CTRL_IDX 10'h010
`define EDCM_A_LOW_IDX 10'h011
`define EDCM_A_HIGH_IDX 10'h012
`define EDCM_A_RES_IDX 10'h013
`define EDCM_B_LOW_IDX 10'h014
`define EDCM_B_HIGH_IDX 10'h015
`define EDCM_B_RES_IDX 10'h016
`define EDCM_A_CHAN_IDX 10'h071
`define EDCM_B_CHAN_IDX 10'h072

// Field positions
`define EDCM_EN_A_BIT 0
`define EDCM_EN_B_BIT 1
`define EDCM_FLAG_A_BIT 2
`define EDCM_FLAG_B_BIT 3
`define EDCM_THR_MSB 6
`define EDCM_SIDE_BIT 7
`define EDCM_CNT_MSB 6

// Reset values
`define EDCM_THR_RST 7'h00
`define EDCM_RES_RST 8'h00
`define EDCM_CTRL_RST 2'h0
`define EDCM_CHAN_RST 8'h00
`define EDCM_CNT_ZERO 7'h00
`define EDCM_CNT_MAX 7'h7F

// Timing
`define EDCM_TICK_US 4000
`define EDCM_CLK_MHZ 100

// AHB codes
`define EDCM_HSIZE_WORD 3'h2
`define EDCM_HRESP_OKAY 1'h0

`endif

/* File: tb/edcm_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module edcm_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq_a,
    input wire logic irq_b
);
    logic rd_reg;
    logic [9:0] idx_reg;
    // Read data phase tracking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_reg <= 1'b0;
            idx_reg <= 10'h000;
        end else begin
            rd_reg <= hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
            idx_reg <= haddr[11:2];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ready_high_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    idle_data_a: assert property (!rd_reg |-> hrdata == 32'h00000000)
        else $error("hrdata outside read");
    upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
        else $error("hrdata upper bits set");
    thr_code_a: assert property (
        rd_reg && idx_reg inside {10'h011, 10'h012, 10'h014, 10'h015} |-> !hrdata[7])
        else $error("threshold bit 7 set");
    unmapped_zero_a: assert property (
        rd_reg && idx_reg inside {[10'h017:10'h070]} |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    pulse_a_a: assert property (irq_a |=> !irq_a)
        else $error("irq_a too long");
    pulse_b_a: assert property ($rose(irq_b) |=> $fell(irq_b))
        else $error("irq_b too long");
endmodule // edcm_checker
bind edcm_top edcm_checker chk_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_a(irq_a), .irq_b(irq_b));
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pcm_valid = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h70DB4C0E, v, rd_q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] pcm_channel = 8'h00, pcm_data = 8'h00;
    logic [9:0] regs [0:9] = '{10'h010, 10'h011, 10'h012, 10'h013, 10'h014, 10'h015,
        10'h016, 10'h071, 10'h072, 10'h020};
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq_a, irq_b, hready;
    int n_errors = 0, num_checks = 0, cyc = 0;
    int model [0:127] = '{default: 0};
    assign hready = hreadyout;
    edcm_top #(.TICK_CYCLES(10)) uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pcm_valid(pcm_valid),
        .pcm_channel(pcm_channel), .pcm_data(pcm_data), .irq_a(irq_a), .irq_b(irq_b));
    initial forever #5 mclk = ~mclk;
    always @(negedge mclk) rd_q = hrdata;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int msk(input [9:0] i);
        case (i)
            10'h010: msk = 3;
            10'h011, 10'h012, 10'h014, 10'h015: msk = 127;
            10'h071, 10'h072: msk = 255;
            default: msk = 0;
        endcase
    endfunction
    task automatic chk(input string what, input [31:0] seen, input [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input [9:0] idx, input w, input [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        v = rd_q;
        hsel <= 1'b0;
    endtask
    task automatic wr(input [9:0] idx, input [31:0] d);
        bus(idx, 1'b1, d);
        model[idx] = d & msk(idx);
    endtask
    task automatic smp(input [7:0] ch, input [6:0] mag);
        @(posedge mclk);
        seed = lfsr(seed);
        pcm_valid <= 1'b1;
        pcm_channel <= ch;
        pcm_data <= {seed[0], mag};
        @(posedge mclk);
        pcm_valid <= 1'b0;
    endtask
    task automatic wirq(input d, input int n, input exp, input string what);
        bit got;
        got = 0;
        repeat (n) begin
            @(negedge mclk);
            if ((d ? irq_b : irq_a) === 1'b1) got = 1;
        end
        chk(what, got, exp);
    endtask
    task automatic det(input d);
        int b;
        b = d ? 3 : 0;
        wr(10'h011 + b, 32'h0A);
        wr(10'h012 + b, 32'h32);
        wr(10'h071 + d, 32'h05 + d);
        wr(10'h010, 32'h1 << d);
        smp(8'h05 + d, 7'h3C);
        wirq(d, 4, 0, "first");
        repeat (36) @(posedge mclk);
        smp(8'h05 + d, 7'h05);
        wirq(d, 4, 1, "fall");
        bus(10'h013 + b, 1'b0, 32'h0);
        chk("side", v[7], 0);
        chk("cnt", v[6:0] >= 3 && v[6:0] <= 5, 1);
        smp(8'h04, 7'h7F);
        smp(8'h05 + d, 7'h32);
        wirq(d, 4, 0, "equal");
        smp(8'h05 + d, 7'h33);
        wirq(d, 4, 1, "rise");
        wirq(d, 1000, 0, "early");
        wirq(d, 400, 1, "max");
        bus(10'h013 + b, 1'b0, 32'h0);
        chk("maxres", v, 32'hFF);
        bus(10'h010, 1'b0, 32'h0);
        chk("flagkept", v, model[10'h010] | (32'h4 << d));
        wr(10'h010, 32'h0);
        bus(10'h013 + b, 1'b0, 32'h0);
        chk("clear", v, 0);
        bus(10'h010, 1'b0, 32'h0);
        chk("flagclr", v, 0);
        $display("test detector %0d done", d);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            bus(regs[i], 1'b0, 32'h0);
            chk("reset", v, 0);
        end
        $display("test reset done");
        for (int i = 1; i < 10; i++) begin
            seed = lfsr(seed);
            wr(regs[i], seed);
        end
        for (int i = 1; i < 10; i++) begin
            bus(regs[i], 1'b0, 32'h0);
            chk("reg", v, model[regs[i]]);
        end
        $display("test access done");
        det(1'b0);
        det(1'b1);
        summarize();
    end
endmodule // tb
`default_nettype wire
